// ---- verilog/lti_host.sv ----
// Purpose: host controller driving the sensor link from axi4-lite
// Assumes: software orders one link operation at a time
// Notes: command ignored while busy
`timescale 1ns/10ps
module lti_host
  import lti_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  lti_link_if.host         link
);
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_D0, H_D1, H_RD, H_WAIT}
    lti_state_e;
  lti_state_e  state_reg, state_next;
  lti_op_e     op_reg, op_next;
  logic [15:0] data_reg, data_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        valid_reg, valid_next;
  logic        first_reg, first_next;
  logic        read_reg, read_next;
  logic [7:0]  byte_reg, byte_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        alert_meta_reg, alert_sync_reg;
  logic        wr_take;
  logic [4:0]  cmd_addr;
  logic [7:0]  wmask;

  assign wr_take  = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign cmd_addr = s_axi_wdata[CMD_ADDR_HI:CMD_ADDR_LO];
  always_comb
  begin
    unique case (cmd_addr)
      ADDR_ALERT_MODE_SELECT_CTRL: wmask = ALERT_MODE_SELECT_CTRL_MASK;
      ADDR_GAIN:      wmask = GAIN_MASK;
      default:        wmask = 8'hFF;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    data_next  = data_reg;
    rdata_next = rdata_reg;
    valid_next = 1'b0;
    first_next = 1'b0;
    read_next  = 1'b0;
    byte_next  = byte_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next  = rresp_reg;
    rdat_next   = rdat_reg;
    if (wr_take)
    begin
      bvalid_next = 1'b1;
      bresp_next  = (s_axi_awaddr == HOST_CMD) ? RESP_OKAY : RESP_SLVERR;
    end
    if (!rvalid_reg && s_axi_arvalid)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      unique case (s_axi_araddr)
        HOST_STATUS: rdat_next = {30'h0, !alert_sync_reg,
                                  state_reg != H_IDLE};
        HOST_RDATA:  rdat_next = {24'h0, rdata_reg};
        default:
        begin
          rdat_next  = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    unique case (state_reg)
      H_IDLE:
        if (wr_take && s_axi_awaddr == HOST_CMD && s_axi_wstrb == 4'hF)
        begin
          op_next    = lti_op_e'(s_axi_wdata[CMD_OP_HI:CMD_OP_LO]);
          data_next  = s_axi_wdata[CMD_DATA_HI:CMD_DATA_LO] &
                       {8'hFF, wmask};
          valid_next = 1'b1;
          first_next = 1'b1;
          byte_next  = {1'b1, KIND_BYTE, cmd_addr};
          if (op_next == OP_WR_WORD)
            byte_next = {1'b1, KIND_WORD, cmd_addr};
          if (op_next == OP_CLEAR)
            byte_next = {1'b1, KIND_SPECIAL, cmd_addr};
          state_next = H_CMD;
        end
      H_CMD:
        if (op_reg == OP_CLEAR)
          state_next = H_IDLE;
        else if (op_reg == OP_RD_BYTE)
        begin
          valid_next = 1'b1;
          read_next  = 1'b1;
          state_next = H_RD;
        end
        else
        begin
          valid_next = 1'b1;
          byte_next  = data_reg[7:0];
          state_next = H_D0;
        end
      H_D0:
        if (op_reg == OP_WR_WORD)
        begin
          valid_next = 1'b1;
          byte_next  = data_reg[15:8];
          state_next = H_D1;
        end
        else
          state_next = H_IDLE;
      H_D1:
        state_next = H_IDLE;
      H_RD:
        state_next = H_WAIT;
      H_WAIT:
        if (link.resp_valid)
        begin
          rdata_next = link.resp_byte;
          state_next = H_IDLE;
        end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= H_IDLE;
      op_reg    <= OP_WR_BYTE;
      data_reg  <= 16'h0;
      rdata_reg <= 8'h0;
      valid_reg <= 1'b0;
      first_reg <= 1'b0;
      read_reg  <= 1'b0;
      byte_reg  <= 8'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdat_reg   <= 32'h0;
      alert_meta_reg <= 1'b1;
      alert_sync_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      op_reg    <= op_next;
      data_reg  <= data_next;
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
      first_reg <= first_next;
      read_reg  <= read_next;
      byte_reg  <= byte_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdat_reg   <= rdat_next;
      alert_meta_reg <= link.alert_n;
      alert_sync_reg <= alert_meta_reg;
    end
  end

  assign s_axi_awready  = wr_take;
  assign s_axi_wready   = wr_take;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = !rvalid_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rresp    = rresp_reg;
  assign s_axi_rdata    = rdat_reg;
  assign link.cmd_valid = valid_reg;
  assign link.cmd_first = first_reg;
  assign link.cmd_read  = read_reg;
  assign link.cmd_byte  = byte_reg;
endmodule : lti_host

// ---- verilog/lti_pkg.sv ----
// Purpose: shared constants for the light threshold interrupt link
// Assumes: byte-level link, one clock for both ends
// Notes: register map as seen by the host over the link
// Contract
// - alert pin open-drain, low when asserted
// - level mode asserts on out-of-window result
// - command kind 11 clears latched alert
// - stop bit halts integration on alert
// - host restarts: enable off, clear, enable on
// - mode 00 off, 01 level, 10 reserved
// - mode 11 forces alert for testing
// - persist 0000 alerts every conversion
// - persist 0001 alerts on any outlier
// - persist 2..15 needs that many periods
// - only channel 0 result is compared
// - result at or below low limit alerts
// - result above high limit alerts
// - limits are 16-bit byte pairs 3h..6h
// - limit bytes reset to 00h
// - lone byte with msb set is pointer
// - host writes limits as word writes
// - gain field 1:0 selects analog gain
// - host writes reserved bits as zero
// - control and gain registers reset 00h
// - identification read-only part and revision
package lti_pkg;
  localparam logic [4:0] ADDR_ALERT_MODE_SELECT_CTRL = 5'h02;
  localparam logic [4:0] ADDR_LOW_LSB   = 5'h03;
  localparam logic [4:0] ADDR_LOW_MSB   = 5'h04;
  localparam logic [4:0] ADDR_HIGH_LSB  = 5'h05;
  localparam logic [4:0] ADDR_HIGH_MSB  = 5'h06;
  localparam logic [4:0] ADDR_GAIN      = 5'h07;
  localparam logic [4:0] ADDR_IDENT     = 5'h12;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam int CMD_BIT       = 7;
  localparam int KIND_HI       = 6;
  localparam int KIND_LO       = 5;
  localparam int STOP_BIT      = 6;
  localparam int MODE_HI       = 5;
  localparam int MODE_LO       = 4;
  localparam int PERSIST_HI    = 3;
  localparam int PERSIST_LO    = 0;
  localparam int GAIN_HI       = 1;
  localparam int GAIN_LO       = 0;
  localparam logic [7:0] ALERT_MODE_SELECT_CTRL_MASK = 8'h7F;
  localparam logic [7:0] GAIN_MASK      = 8'h03;
  localparam logic [1:0] KIND_BYTE    = 2'h0;
  localparam logic [1:0] KIND_WORD    = 2'h1;
  localparam logic [1:0] KIND_SPECIAL = 2'h3;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_LEVEL   = 2'h1;
  localparam logic [1:0] MODE_TEST    = 2'h3;
  localparam logic [3:0] PERSIST_MAX  = 4'hF;
  // host register map over axi4-lite
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_RDATA  = 8'h08;
  localparam int CMD_DATA_LO = 0;
  localparam int CMD_DATA_HI = 15;
  localparam int CMD_ADDR_LO = 16;
  localparam int CMD_ADDR_HI = 20;
  localparam int CMD_OP_LO   = 24;
  localparam int CMD_OP_HI   = 25;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OP_WR_BYTE, OP_WR_WORD, OP_RD_BYTE, OP_CLEAR}
    lti_op_e;
endpackage : lti_pkg

// ---- verilog/lti_link_if.sv ----
// Purpose: link between host controller and sensor interrupt logic
// Assumes: both ends on aclk; alert pin resolved here
// Notes: pull-up modelled by the resolution of alert_n
`timescale 1ns/10ps
interface lti_link_if;
  logic       cmd_valid;
  logic       cmd_first;
  logic       cmd_read;
  logic [7:0] cmd_byte;
  logic       resp_valid;
  logic [7:0] resp_byte;
  logic       alert_n_out;
  logic       alert_n_oe;
  logic       alert_n;
  // open-drain wire with external pull-up
  assign alert_n = alert_n_oe ? alert_n_out : 1'b1;
  modport dev  (input cmd_valid, input cmd_first, input cmd_read,
                input cmd_byte, output resp_valid, output resp_byte,
                output alert_n_out, output alert_n_oe);
  modport host (output cmd_valid, output cmd_first, output cmd_read,
                output cmd_byte, input resp_valid, input resp_byte,
                input alert_n);
endinterface : lti_link_if

// ---- verilog/lti_persist.sv ----
// Purpose: window compare and persistence count on channel 0
// Assumes: sample_valid pulses once per finished conversion
// Notes: fire is a one-cycle pulse
`timescale 1ns/10ps
module lti_persist
  import lti_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample,
  input  wire logic [15:0] low_limit,
  input  wire logic [15:0] high_limit,
  input  wire logic [3:0]  persist,
  output logic             fire
);
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] count_inc;
  logic       out_of_range;

  always_comb
  begin
    out_of_range = (sample <= low_limit) ||
                   (sample > high_limit);
    count_inc = (count_reg == PERSIST_MAX) ? PERSIST_MAX
                                           : count_reg + 4'h1;
    fire = sample_valid &&
           ((persist == 4'h0) ||
            (out_of_range && count_inc >= persist));
    count_next = count_reg;
    if (sample_valid)
    begin
      count_next = out_of_range ? count_inc : 4'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= 4'h0;
    else
      count_reg <= count_next;
  end
endmodule : lti_persist

// ---- verilog/lti_device.sv ----
// Purpose: sensor-side interrupt control, limits, gain and id registers
// Assumes: conversion results arrive as ch0 word with a done pulse
// Notes: second channel is never wired in
`timescale 1ns/10ps
module lti_device
  import lti_pkg::*;
#(
  parameter logic [3:0] PART_CODE = 4'hA,  // arbitrary value
  parameter logic [3:0] REV_CODE  = 4'h1   // arbitrary value
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  lti_link_if.dev          link,
  input  wire logic        conv_done,
  input  wire logic [15:0] ch0_result,
  input  wire logic        adc_enable,
  output logic             integrate_enable,
  output logic [1:0]       gain_field
);
  logic [7:0] alert_mode_select_ctrl_reg;
  logic [7:0] alert_mode_select_ctrl_next;
  logic [7:0] low_lsb_reg;
  logic [7:0] low_lsb_next;
  logic [7:0] low_msb_reg;
  logic [7:0] low_msb_next;
  logic [7:0] high_lsb_reg;
  logic [7:0] high_lsb_next;
  logic [7:0] high_msb_reg;
  logic [7:0] high_msb_next;
  logic [7:0] gain_reg;
  logic [7:0] gain_next;
  logic [4:0] ptr_reg;
  logic [4:0] ptr_next;
  logic       alert_reg;
  logic       alert_next;
  logic       halt_reg;
  logic       halt_next;
  logic       resp_valid_reg;
  logic       resp_valid_next;
  logic [7:0] resp_byte_reg;
  logic [7:0] resp_byte_next;
  logic [7:0] read_mux;
  logic       clear_alert;
  logic       fire;
  logic       set_alert;
  logic [1:0] alert_mode_select;
  logic       stop_on_alert;

  assign alert_mode_select = alert_mode_select_ctrl_reg[MODE_HI:MODE_LO];
  assign stop_on_alert     = alert_mode_select_ctrl_reg[STOP_BIT];

  lti_persist u_persist
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .sample_valid (conv_done),
    .sample       (ch0_result),
    .low_limit    ({low_msb_reg, low_lsb_reg}),
    .high_limit   ({high_msb_reg, high_lsb_reg}),
    .persist      (alert_mode_select_ctrl_reg[PERSIST_HI:PERSIST_LO]),
    .fire         (fire)
  );

  // register read view
  always_comb
  begin
    unique case (ptr_reg)
      ADDR_ALERT_MODE_SELECT_CTRL: read_mux = alert_mode_select_ctrl_reg;
      ADDR_LOW_LSB:   read_mux = low_lsb_reg;
      ADDR_LOW_MSB:   read_mux = low_msb_reg;
      ADDR_HIGH_LSB:  read_mux = high_lsb_reg;
      ADDR_HIGH_MSB:  read_mux = high_msb_reg;
      ADDR_GAIN:      read_mux = gain_reg;
      ADDR_IDENT:     read_mux = {PART_CODE, REV_CODE};
      default:        read_mux = RESET_BYTE;
    endcase
  end

  // link decode and register writes
  always_comb
  begin
    alert_mode_select_ctrl_next  = alert_mode_select_ctrl_reg;
    low_lsb_next    = low_lsb_reg;
    low_msb_next    = low_msb_reg;
    high_lsb_next   = high_lsb_reg;
    high_msb_next   = high_msb_reg;
    gain_next       = gain_reg;
    ptr_next        = ptr_reg;
    resp_valid_next = 1'b0;
    resp_byte_next  = resp_byte_reg;
    clear_alert     = 1'b0;
    if (link.cmd_valid)
    begin
      if (link.cmd_read)
      begin
        resp_valid_next = 1'b1;
        resp_byte_next  = read_mux;
        ptr_next        = ptr_reg + 5'h01;
      end
      else if (link.cmd_first && link.cmd_byte[CMD_BIT])
      begin
        ptr_next = link.cmd_byte[4:0];
        if (link.cmd_byte[KIND_HI:KIND_LO] == KIND_SPECIAL)
        begin
          clear_alert = 1'b1;
        end
      end
      else
      begin
        unique case (ptr_reg)
          ADDR_ALERT_MODE_SELECT_CTRL: alert_mode_select_ctrl_next = link.cmd_byte;
          ADDR_LOW_LSB:   low_lsb_next   = link.cmd_byte;
          ADDR_LOW_MSB:   low_msb_next   = link.cmd_byte;
          ADDR_HIGH_LSB:  high_lsb_next  = link.cmd_byte;
          ADDR_HIGH_MSB:  high_msb_next  = link.cmd_byte;
          ADDR_GAIN:      gain_next      = link.cmd_byte;
          default:        ptr_next       = ptr_reg;
        endcase
        ptr_next = ptr_reg + 5'h01;
      end
    end
  end

  // alert latch and integration halt
  always_comb
  begin
    set_alert = ((alert_mode_select == MODE_LEVEL) && fire) ||
                (alert_mode_select == MODE_TEST);
    alert_next = alert_reg;
    if (clear_alert)
      alert_next = 1'b0;
    if (set_alert)
      alert_next = 1'b1;
    halt_next = halt_reg;
    if (stop_on_alert && alert_reg)
      halt_next = 1'b1;
    else if (!adc_enable && !alert_reg)
      halt_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alert_mode_select_ctrl_reg  <= RESET_BYTE;
      low_lsb_reg    <= RESET_BYTE;
      low_msb_reg    <= RESET_BYTE;
      high_lsb_reg   <= RESET_BYTE;
      high_msb_reg   <= RESET_BYTE;
      gain_reg       <= RESET_BYTE;
      ptr_reg        <= 5'h00;
      alert_reg      <= 1'b0;
      halt_reg       <= 1'b0;
      resp_valid_reg <= 1'b0;
      resp_byte_reg  <= RESET_BYTE;
    end
    else
    begin
      alert_mode_select_ctrl_reg  <= alert_mode_select_ctrl_next;
      low_lsb_reg    <= low_lsb_next;
      low_msb_reg    <= low_msb_next;
      high_lsb_reg   <= high_lsb_next;
      high_msb_reg   <= high_msb_next;
      gain_reg       <= gain_next;
      ptr_reg        <= ptr_next;
      alert_reg      <= alert_next;
      halt_reg       <= halt_next;
      resp_valid_reg <= resp_valid_next;
      resp_byte_reg  <= resp_byte_next;
    end
  end

  assign link.resp_valid  = resp_valid_reg;
  assign link.resp_byte   = resp_byte_reg;
  assign link.alert_n_out = 1'b0;
  assign link.alert_n_oe  = alert_reg;
  assign integrate_enable = adc_enable && !halt_reg;
  assign gain_field       = gain_reg[GAIN_HI:GAIN_LO];
endmodule : lti_device

// ---- sim/lti_chk.sv ----
// Purpose: link checks between host end and device end
// Assumes: one clock, reset synchronous active low
// Notes: watches only the interface signals
`timescale 1ns/10ps
module lti_chk
  import lti_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_first,
  input wire logic       cmd_read,
  input wire logic [7:0] cmd_byte,
  input wire logic       resp_valid,
  input wire logic [7:0] resp_byte,
  input wire logic       alert_n_out,
  input wire logic       alert_n_oe,
  input wire logic       alert_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic       ptr_go;
  logic [1:0] kind;
  assign ptr_go = cmd_valid & cmd_first & cmd_byte[CMD_BIT];
  assign kind   = cmd_byte[KIND_HI:KIND_LO];
  chk_drain_low: assert property (
    alert_n_oe |-> !alert_n_out && !alert_n)
    else $error("alert pin not pulled low");
  chk_pin_idle: assert property (
    !alert_n_oe |-> alert_n)
    else $error("alert pin low while released");
  chk_clear_only: assert property (
    $fell(alert_n_oe) |-> $past(ptr_go && kind == KIND_SPECIAL))
    else $error("alert released without clear");
  chk_clear_frame: assert property (
    ptr_go && kind == KIND_SPECIAL |=> !cmd_valid)
    else $error("clear not a lone byte");
  chk_word_frame: assert property (
    ptr_go && kind == KIND_WORD
      |=> (cmd_valid && !cmd_first)[*2] ##1 !cmd_valid)
    else $error("word write not pointer plus two bytes");
  chk_byte_frame: assert property (
    ptr_go && kind == KIND_BYTE |=> cmd_valid ##1 !cmd_valid)
    else $error("byte access not pointer plus one step");
  chk_first_ptr: assert property (
    cmd_valid && cmd_first |-> cmd_byte[CMD_BIT] && !cmd_read)
    else $error("first byte is not a pointer");
  chk_read_answer: assert property (
    cmd_valid && cmd_read |=> resp_valid ##1 !resp_valid)
    else $error("read step not answered once");
  chk_resp_cause: assert property (
    resp_valid |-> $past(cmd_valid && cmd_read))
    else $error("answer without read step");
  chk_resp_hold: assert property (
    $changed(resp_byte) |-> resp_valid)
    else $error("read data changed between reads");
  cover property (ptr_go && kind == KIND_WORD);
  cover property ($fell(alert_n_oe));
  cover property (resp_valid);
endmodule : lti_chk

// ---- sim/testbench.sv ----
// Purpose: host and device ends joined, driven over axi4-lite
// Assumes: one link operation at a time
// Notes: conversions injected on the device side
`timescale 1ns/10ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: %s", $time, m); end end
module testbench
  import lti_pkg::*;
;
  localparam logic [3:0] PART = 4'hA;  // arbitrary value
  localparam logic [3:0] REV  = 4'h1;  // arbitrary value
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic        conv_done = 0, adc_enable = 0, integrate_enable;
  logic [15:0] ch0_result = 0;
  logic [1:0]  gain_field;
  logic [31:0] r;
  logic [1:0]  rs;
  logic [7:0]  b;
  int          bad_count = 0, checked = 0;
  always #10 aclk = ~aclk;
  lti_link_if link_if();
  lti_device #(.PART_CODE(PART), .REV_CODE(REV)) lti_device_inst (
    .aclk(aclk), .aresetn(aresetn), .link(link_if), .conv_done(conv_done),
    .ch0_result(ch0_result), .adc_enable(adc_enable),
    .integrate_enable(integrate_enable), .gain_field(gain_field));
  lti_host lti_host_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));
  lti_chk lti_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .cmd_valid(link_if.cmd_valid),
    .cmd_first(link_if.cmd_first), .cmd_read(link_if.cmd_read),
    .cmd_byte(link_if.cmd_byte), .resp_valid(link_if.resp_valid),
    .resp_byte(link_if.resp_byte), .alert_n_out(link_if.alert_n_out),
    .alert_n_oe(link_if.alert_n_oe), .alert_n(link_if.alert_n));
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic lk(input lti_op_e op, input logic [4:0] a,
                    input logic [15:0] d);
    logic [31:0] v;
    logic [1:0]  e;
    axi_wr(HOST_CMD, {6'h00, op, 3'h0, a, d}, e);
    `CHK(e, RESP_OKAY, "command response")
    do axi_rd(HOST_STATUS, v, e); while (v[0] !== 1'b0);
  endtask : lk
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    logic [31:0] v;
    logic [1:0]  e;
    lk(OP_RD_BYTE, a, 16'h0000);
    axi_rd(HOST_RDATA, v, e);
    q = v[7:0];
  endtask : rd
  task automatic ctl(input logic [7:0] v);
    lk(OP_WR_BYTE, ADDR_ALERT_MODE_SELECT_CTRL, {8'h00, v});
  endtask : ctl
  task automatic clr;
    lk(OP_CLEAR, 5'h00, 16'h0000);
  endtask : clr
  task automatic cv(input logic [15:0] v);
    @(posedge aclk);
    conv_done <= 1'b1; ch0_result <= v;
    @(posedge aclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : cv
  task stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    stop_test;
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1; adc_enable <= 1'b1;
    for (int a = 2; a < 8; a++)
    begin
      rd(a[4:0], b); `CHK(b, RESET_BYTE, "reset value")
    end
    rd(ADDR_IDENT, b); `CHK(b, {PART, REV}, "id value")
    lk(OP_WR_BYTE, ADDR_IDENT, 16'h0055);
    rd(ADDR_IDENT, b); `CHK(b, {PART, REV}, "id written")
    axi_rd(8'h0C, r, rs); `CHK({rs, r}, {RESP_SLVERR, 32'h0}, "unmapped")
    axi_wr(8'h10, 32'h1, rs); `CHK(rs, RESP_SLVERR, "unmapped write")
    for (int g = 0; g < 4; g++)
    begin
      lk(OP_WR_BYTE, ADDR_GAIN, {14'h0, g[1:0]});
      `CHK(gain_field, g[1:0], "gain pins")
      rd(ADDR_GAIN, b); `CHK(b, {6'h0, g[1:0]}, "gain readback")
    end
    lk(OP_WR_BYTE, ADDR_GAIN, 16'h00FF);
    rd(ADDR_GAIN, b); `CHK(b, 8'h03, "gain reserved zero")
    $display("test registers done");
    lk(OP_WR_WORD, ADDR_LOW_LSB, 16'h0100);
    lk(OP_WR_WORD, ADDR_HIGH_LSB, 16'h0200);
    rd(ADDR_LOW_MSB, b); `CHK(b, 8'h01, "low limit msb")
    rd(ADDR_HIGH_MSB, b); `CHK(b, 8'h02, "high limit msb")
    ctl(8'h11);
    cv(16'h0150); `CHK(link_if.alert_n, 1'b1, "in window")
    cv(16'h0100); `CHK(link_if.alert_n, 1'b0, "equal low")
    axi_rd(HOST_STATUS, r, rs); `CHK(r[1], 1'b1, "status alert")
    clr; `CHK(link_if.alert_n, 1'b1, "cleared")
    cv(16'h0200); `CHK(link_if.alert_n, 1'b1, "equal high")
    cv(16'h0201); `CHK(link_if.alert_n, 1'b0, "above high")
    clr;
    $display("test window done");
    for (int k = 0; k < 3; k++)
    begin
      automatic int p = (k == 0) ? 2 : (k == 1) ? 3 : 15;
      ctl({4'h1, p[3:0]});
      cv(16'h0150);
      clr;
      repeat (p - 1) cv(16'h0000);
      cv(16'h0150);
      repeat (p - 1) cv(16'h0000);
      `CHK(link_if.alert_n, 1'b1, "short run")
      cv(16'h0000); `CHK(link_if.alert_n, 1'b0, "full run")
      clr;
    end
    ctl(8'h10);
    cv(16'h0150); `CHK(link_if.alert_n, 1'b0, "every cycle")
    ctl(8'h01); clr;
    cv(16'h0000); `CHK(link_if.alert_n, 1'b1, "mode off")
    ctl(8'h21);
    cv(16'h0000); `CHK(link_if.alert_n, 1'b1, "mode reserved")
    ctl(8'h31);
    repeat (3) @(posedge aclk);
    `CHK(link_if.alert_n, 1'b0, "test mode")
    ctl(8'h01); clr;
    $display("test persistence and modes done");
    ctl(8'h51);
    cv(16'h0000); `CHK(integrate_enable, 1'b0, "halted")
    @(posedge aclk);
    adc_enable <= 1'b0;
    clr;
    @(posedge aclk);
    adc_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(integrate_enable, 1'b1, "restarted")
    $display("test stop done");
    ctl(8'h31);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(link_if.alert_n, 1'b1, "reset drops alert")
    rd(ADDR_ALERT_MODE_SELECT_CTRL, b); `CHK(b, RESET_BYTE, "reset ctrl")
    $display("test mid-run reset done");
    stop_test;
  end
endmodule : testbench
